/* File: common/test_mux_defs.vh */
// Function
// - Selector code 0 drives the three pins from the static 3-bit field
// - Selector code 1 puts buffered crystal reference on pin 3
// - Selector code 1 puts reference divider on pin 2, prescaler on pin 1
// - Selector is four bits at 3:0 of output config register
// - Code 2: lock window pin 1, detector up pin 3, down pin 2
// - Code 3: ref faster pin 3, VCO faster pin 2, max-gain strobe pin 1
// - Slip indicators live during pull-in; max-gain strobe holds until lock
// - Fractional register write makes synchronized strobe starting modulator update
// - Code 4: frequency strobe pin 1, ref divider pin 2, sine ref pin 3
// - Code 6: top three first-accumulator bits on pins 3 to 1
// - Code 7: aux clock pin 3, ring oscillator pin 2, modulator clock pin 1
// - Aux clock source selects VCO clocks, crystal clocks or ring oscillator
// - Aux clock delay from bits 3:2, even divide 2 to 16 from bits 6:4
// - Code 10: three low modulator output bits on pins 3 to 1
// - Detector control bit 0 inverts phase detector sense
// - Detector control bit 1 clear masks up output
// - Detector control bit 2 clear masks down output
// - Both enables clear tri-states charge pump, rest keeps running
`ifndef TEST_MUX_DEFS_VH
`define TEST_MUX_DEFS_VH

// Register offsets
`define ADDR_PD_CTRL     5'h05
`define ADDR_AUX_CFG     5'h18
`define ADDR_AUX_SRC     5'h19
`define ADDR_OUT_CFG     5'h1b
`define ADDR_FRAC        5'h0c
`define ADDR_STATUS      5'h1f

// Field positions
`define SEL_LSB          0
`define SEL_MSB          3
`define STATIC_LSB       4
`define STATIC_MSB       6
`define PD_INV_BIT       0
`define PD_UP_EN_BIT     1
`define PD_DN_EN_BIT     2
`define AUX_DLY_LSB      2
`define AUX_DLY_MSB      3
`define AUX_DIV_LSB      4
`define AUX_DIV_MSB      6
`define AUX_SRC_LSB      0
`define AUX_SRC_MSB      1

// Reset values
`define RST_OUT_CFG      7'h00
`define RST_PD_CTRL      3'h6
`define RST_AUX_CFG      7'h00
`define RST_AUX_SRC      2'h0
`define RST_FRAC         24'h000000

// Selector codes
`define SEL_STATIC       4'h0
`define SEL_DIVIDERS     4'h1
`define SEL_LOCKWIN      4'h2
`define SEL_SLIP         4'h3
`define SEL_FRAC_STB     4'h4
`define SEL_ACCUM        4'h6
`define SEL_AUX          4'h7
`define SEL_MOD_OUT      4'ha

// Aux clock sources
`define AUX_SRC_VCO      2'h0
`define AUX_SRC_XTAL     2'h1
`define AUX_SRC_RING     2'h2

`endif

/* File: rtl/aux_clock_gen.v */
`timescale 1ns/100ps
`include "test_mux_defs.vh"
module aux_clock_gen
(
	input  wire       clk,
	input  wire       rst,
	input  wire [1:0] src_sel,
	input  wire [1:0] delay_sel,
	input  wire [2:0] div_sel,
	input  wire       vco_clk,
	input  wire       xtal_clk,
	input  wire       ring_clk,
	output reg        aux_out
);

	reg       src;
	reg [3:0] cnt;
	reg       div_q;
	reg [2:0] dly;
	wire [3:0] half;

	// Half period of even divide 2..16
	assign half = {1'b0, div_sel} + 4'h1;

	// Source pick
	always @*
	begin
		case (src_sel)
			`AUX_SRC_VCO:  src = vco_clk;
			`AUX_SRC_XTAL: src = xtal_clk;
			`AUX_SRC_RING: src = ring_clk;
			default:       src = 1'b0;
		endcase
	end

	// Divider on rising samples of the source
	reg src_d;
	always @(posedge clk)
	begin
		if (rst)
		begin
			src_d <= 1'b0;
			cnt   <= 4'h0;
			div_q <= 1'b0;
			dly   <= 3'h0;
			aux_out <= 1'b0;
		end
		else
		begin
			src_d <= src;
			if (src & ~src_d)
			begin
				if (cnt + 4'h1 >= half)
				begin
					cnt   <= 4'h0;
					div_q <= ~div_q;
				end
				else
					cnt <= cnt + 4'h1;
			end
			dly <= {dly[1:0], div_q};
			// Delay tap select
			case (delay_sel)
				2'h0:    aux_out <= div_q;
				2'h1:    aux_out <= dly[0];
				2'h2:    aux_out <= dly[1];
				default: aux_out <= dly[2];
			endcase
		end
	end

endmodule

/* File: rtl/pin_sync.v */
`timescale 1ns/100ps
module pin_sync
#(
	parameter WIDTH = 1
)
(
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);

	reg [WIDTH-1:0] meta;

	// Two-stage synchroniser
	always @(posedge clk)
	begin
		if (rst)
		begin
			meta <= {WIDTH{1'b0}};
			q    <= {WIDTH{1'b0}};
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

/* File: rtl/synth_test_output_mux.v */
`timescale 1ns/100ps
`include "test_mux_defs.vh"
module synth_test_output_mux
(
	input  wire        REF_CLK,
	input  wire        RST,
	input  wire [4:0]  ADDR,
	input  wire [31:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [31:0] RDATA,
	input  wire        XTAL_REF,
	input  wire        SINE_REF,
	input  wire        REF_DIV_OUT,
	input  wire        PRESCALER_OUT,
	input  wire        LOCK_WINDOW,
	input  wire        PD_UP,
	input  wire        PD_DN,
	input  wire        REF_FASTER,
	input  wire        VCO_FASTER,
	input  wire        MAX_GAIN,
	input  wire        LOCKED,
	input  wire [2:0]  ACCUM_MSB,
	input  wire [2:0]  MOD_OUT_LSB,
	input  wire        RING_OSC,
	input  wire        MOD_CLK,
	input  wire        VCO_CLK,
	output reg         TEST_PIN_1,
	output reg         TEST_PIN_2,
	output reg         TEST_PIN_3,
	output reg         CP_UP,
	output reg         CP_DN,
	output reg         CP_OE,
	output reg  [23:0] FRAC_VALUE,
	output reg         FRAC_UPDATE
);

	////////////////////////////////////////////////////////////////
	// Registers
	reg [6:0]  out_cfg;
	reg [2:0]  pd_ctrl;
	reg [6:0]  aux_cfg;
	reg [1:0]  aux_src;
	reg [23:0] frac;
	reg        frac_req;
	reg        frac_ack;
	reg        hold_gain;
	wire [3:0] sel;
	wire       aux_clk;

	// Synchronised pin inputs
	wire [19:0] raw_in;
	wire [19:0] s;
	assign raw_in = {VCO_CLK, MOD_CLK, RING_OSC, MOD_OUT_LSB, ACCUM_MSB,
		LOCKED, MAX_GAIN, VCO_FASTER, REF_FASTER, PD_DN, PD_UP,
		LOCK_WINDOW, PRESCALER_OUT, REF_DIV_OUT, SINE_REF, XTAL_REF};

	pin_sync #(.WIDTH(20)) u_sync
	(
		.clk (REF_CLK),
		.rst (RST),
		.d   (raw_in),
		.q   (s)
	);

	wire xtal   = s[0];
	wire sine   = s[1];
	wire refdiv = s[2];
	wire presc  = s[3];
	wire lkwin  = s[4];
	wire up_raw = s[5];
	wire dn_raw = s[6];
	wire rfast  = s[7];
	wire vfast  = s[8];
	wire maxg   = s[9];
	wire lockd  = s[10];
	wire [2:0] acc  = s[13:11];
	wire [2:0] modo = s[16:14];
	wire ring   = s[17];
	wire mclk   = s[18];
	wire vclk   = s[19];

	assign sel = out_cfg[`SEL_MSB:`SEL_LSB];

	aux_clock_gen u_aux
	(
		.clk       (REF_CLK),
		.rst       (RST),
		.src_sel   (aux_src),
		.delay_sel (aux_cfg[`AUX_DLY_MSB:`AUX_DLY_LSB]),
		.div_sel   (aux_cfg[`AUX_DIV_MSB:`AUX_DIV_LSB]),
		.vco_clk   (vclk),
		.xtal_clk  (xtal),
		.ring_clk  (ring),
		.aux_out   (aux_clk)
	);

	////////////////////////////////////////////////////////////////
	// Register writes and fractional strobe
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			out_cfg  <= `RST_OUT_CFG;
			pd_ctrl  <= `RST_PD_CTRL;
			aux_cfg  <= `RST_AUX_CFG;
			aux_src  <= `RST_AUX_SRC;
			frac     <= `RST_FRAC;
			frac_req <= 1'b0;
		end
		else
		begin
			frac_req <= 1'b0;
			if (WR)
			begin
				case (ADDR)
					`ADDR_OUT_CFG: out_cfg <= WDATA[6:0];
					`ADDR_PD_CTRL: pd_ctrl <= WDATA[2:0];
					`ADDR_AUX_CFG: aux_cfg <= WDATA[6:0];
					`ADDR_AUX_SRC: aux_src <= WDATA[1:0];
					`ADDR_FRAC:
					begin
						frac     <= WDATA[23:0];
						frac_req <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// Strobe and modulator load in the same cycle, aligned to the reference divider rising edge
	reg refdiv_d;
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			frac_ack    <= 1'b0;
			refdiv_d    <= 1'b0;
			FRAC_UPDATE <= 1'b0;
			FRAC_VALUE  <= `RST_FRAC;
		end
		else
		begin
			refdiv_d    <= refdiv;
			FRAC_UPDATE <= 1'b0;
			if (frac_req)
				frac_ack <= 1'b1;
			else if (frac_ack & refdiv & ~refdiv_d)
			begin
				frac_ack    <= 1'b0;
				FRAC_UPDATE <= 1'b1;
				FRAC_VALUE  <= frac;
			end
		end
	end

	// Max-gain hold until locked
	always @(posedge REF_CLK)
	begin
		if (RST)
			hold_gain <= 1'b0;
		else if (maxg)
			hold_gain <= 1'b1;
		else if (lockd)
			hold_gain <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Phase detector gating
	wire up_i = pd_ctrl[`PD_INV_BIT] ? dn_raw : up_raw;
	wire dn_i = pd_ctrl[`PD_INV_BIT] ? up_raw : dn_raw;

	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			CP_UP <= 1'b0;
			CP_DN <= 1'b0;
			CP_OE <= 1'b0;
		end
		else
		begin
			CP_UP <= up_i & pd_ctrl[`PD_UP_EN_BIT];
			CP_DN <= dn_i & pd_ctrl[`PD_DN_EN_BIT];
			CP_OE <= pd_ctrl[`PD_UP_EN_BIT] | pd_ctrl[`PD_DN_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// Test pin mux
	reg [2:0] next_pins;
	always @*
	begin
		case (sel)
			`SEL_STATIC:   next_pins = out_cfg[`STATIC_MSB:`STATIC_LSB];
			`SEL_DIVIDERS: next_pins = {xtal, refdiv, presc};
			`SEL_LOCKWIN:  next_pins = {up_i, dn_i, lkwin};
			`SEL_SLIP:     next_pins = {rfast, vfast, maxg | hold_gain};
			`SEL_FRAC_STB: next_pins = {sine, refdiv, FRAC_UPDATE};
			`SEL_ACCUM:    next_pins = acc;
			`SEL_AUX:      next_pins = {aux_clk, ring, mclk};
			`SEL_MOD_OUT:  next_pins = modo;
			default:       next_pins = 3'h0;
		endcase
	end

	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			TEST_PIN_1 <= 1'b0;
			TEST_PIN_2 <= 1'b0;
			TEST_PIN_3 <= 1'b0;
		end
		else
		begin
			TEST_PIN_3 <= next_pins[2];
			TEST_PIN_2 <= next_pins[1];
			TEST_PIN_1 <= next_pins[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port, data one cycle after strobe
	always @(posedge REF_CLK)
	begin
		if (RST)
			RDATA <= 32'h00000000;
		else if (RD)
		begin
			case (ADDR)
				`ADDR_OUT_CFG: RDATA <= {25'h0, out_cfg};
				`ADDR_PD_CTRL: RDATA <= {29'h0, pd_ctrl};
				`ADDR_AUX_CFG: RDATA <= {25'h0, aux_cfg};
				`ADDR_AUX_SRC: RDATA <= {30'h0, aux_src};
				`ADDR_FRAC:    RDATA <= {8'h00, frac};
				`ADDR_STATUS:  RDATA <= {28'h0000000, hold_gain, frac_ack,
					lockd, CP_OE};
				default:       RDATA <= 32'h00000000;
			endcase
		end
		else
			RDATA <= 32'h00000000;
	end

endmodule

/* File: tb/pin_scope.sv */
`timescale 1ns/100ps
module pin_scope
(
	input  wire        clk,
	input  wire        pin,
	output reg  [15:0] edges = 16'h0
);
	reg last = 1'b0;

	// Counts rising edges, as a scope trigger would
	always @(posedge clk)
	begin
		last <= pin;
		edges <= edges + {15'h0, pin & ~last};
	end
endmodule

/* File: tb/synth_test_output_mux_bench.sv */
`timescale 1ns/100ps
module synth_test_output_mux_bench;
	reg         REF_CLK = 1'b0;
	reg         RST = 1'b1;
	reg  [4:0]  ADDR = 5'h00;
	reg  [31:0] WDATA = 32'h0;
	reg         WR = 1'b0;
	reg         RD = 1'b0;
	reg  [19:0] s = 20'h0;
	reg  [31:0] rs = 32'h3b35;
	wire [31:0] RDATA;
	wire        TEST_PIN_1, TEST_PIN_2, TEST_PIN_3, CP_UP, CP_DN, CP_OE;
	wire        FRAC_UPDATE;
	wire [23:0] FRAC_VALUE;
	wire [15:0] edges;
	integer     errors = 0;
	integer     n_compared = 0;
	integer     k, i;
	reg  [19:0] h [$];
	reg  [19:0] x;
	reg  [2:0]  e, q, st, p;
	reg  [3:0]  c;
	reg  [23:0] fv;
	reg  [15:0] n0;
	reg  [19:0] sm, sq;
	reg  [6:0]  acfg;
	reg  [2:0]  dl;
	reg  [1:0]  asel;
	reg         src, sd, dq, ao, ap, hm, hp;
	integer     cn;

	synth_test_output_mux dut (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .XTAL_REF(s[19]),
		.SINE_REF(s[18]), .REF_DIV_OUT(s[17]), .PRESCALER_OUT(s[16]),
		.LOCK_WINDOW(s[15]), .PD_UP(s[14]), .PD_DN(s[13]),
		.REF_FASTER(s[12]), .VCO_FASTER(s[11]), .MAX_GAIN(s[10]),
		.LOCKED(s[9]), .ACCUM_MSB(s[8:6]), .MOD_OUT_LSB(s[5:3]),
		.RING_OSC(s[2]), .MOD_CLK(s[1]), .VCO_CLK(s[0]),
		.TEST_PIN_1(TEST_PIN_1), .TEST_PIN_2(TEST_PIN_2),
		.TEST_PIN_3(TEST_PIN_3), .CP_UP(CP_UP), .CP_DN(CP_DN),
		.CP_OE(CP_OE), .FRAC_VALUE(FRAC_VALUE), .FRAC_UPDATE(FRAC_UPDATE));
	pin_scope scope (.clk(REF_CLK), .pin(TEST_PIN_1), .edges(edges));

	always #5 REF_CLK = ~REF_CLK;

	function [31:0] xs(input [31:0] v);
	begin
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		xs = v ^ (v << 5);
	end
	endfunction

	// Random input levels, with a short history of what was sampled;
	// beside it the sync stages, aux clock and max-gain hold are modelled
	always @(posedge REF_CLK)
	begin
		h.push_front(s);
		if (h.size() > 4)
			h.pop_back();
		ap = ao;
		hp = hm;
		case (asel)
			2'h0:    src = sq[0];
			2'h1:    src = sq[19];
			2'h2:    src = sq[2];
			default: src = 1'b0;
		endcase
		if (RST)
		begin
			sm = 20'h0;
			sq = 20'h0;
			sd = 1'b0;
			cn = 0;
			dq = 1'b0;
			dl = 3'h0;
			ao = 1'b0;
			hm = 1'b0;
			asel = 2'h0;
			acfg = 7'h00;
		end
		else
		begin
			case (acfg[3:2])
				2'h0:    ao = dq;
				2'h1:    ao = dl[0];
				2'h2:    ao = dl[1];
				default: ao = dl[2];
			endcase
			dl = {dl[1:0], dq};
			if (src && !sd)
			begin
				cn = cn + 1;
				if (cn > acfg[6:4])
				begin
					cn = 0;
					dq = !dq;
				end
			end
			sd = src;
			if (sq[10])
				hm = 1'b1;
			else if (sq[9])
				hm = 1'b0;
			if (WR && ADDR == 5'h19)
				asel = WDATA[1:0];
			if (WR && ADDR == 5'h18)
				acfg = WDATA[6:0];
			sq = sm;
			sm = s;
		end
		rs = xs(rs);
		s <= rs[19:0];
	end

	task chk(input [8*5:1] nm, input [31:0] ex, input [31:0] got);
	begin
		n_compared = n_compared + 1;
		if (ex !== got)
		begin
			errors = errors + 1;
			$display("ERROR %0s expected %h seen %h", nm, ex, got);
		end
	end
	endtask

	task wr(input [4:0] a, input [31:0] d);
	begin
		@(posedge REF_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge REF_CLK);
		WR <= 1'b0;
	end
	endtask

	task rd(input [4:0] a, input [31:0] ex);
	begin
		@(posedge REF_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge REF_CLK);
		RD <= 1'b0;
		@(negedge REF_CLK);
		chk("rdata", ex, RDATA);
	end
	endtask

	// Expected pins from inputs three edges back and the modelled state
	task model;
	begin
		x = h[2];
		case (c)
			4'h0: e = st;
			4'h1: e = {x[19], x[17], x[16]};
			4'h2: e = p[0] ? {x[13], x[14], x[15]}
				: {x[14], x[13], x[15]};
			4'h3: e = {x[12:11], x[10] | hp};
			4'h4: e = {x[18:17], 1'b0};
			4'h6: e = x[8:6];
			4'h7: e = {ap, x[2:1]};
			4'ha: e = x[5:3];
			default: e = 3'h0;
		endcase
		q = {(p[0] ? x[13] : x[14]) & p[1], (p[0] ? x[14] : x[13]) & p[2],
			p[1] | p[2]};
	end
	endtask

	task end_of_test;
	begin
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	initial
	begin
		repeat (20) @(posedge REF_CLK);
		RST <= 1'b0;
		wr(5'h19, 32'h3);
		rd(5'h02, 32'h0);
		for (k = 0; k < 128; k = k + 1)
		begin
			c = k[3:0];
			p = k[6:4];
			st = rs[2:0];
			wr(5'h1b, {st, c});
			wr(5'h05, p);
			rd(5'h1b, {st, c});
			repeat (8)
			begin
				@(negedge REF_CLK);
				model;
				chk("pins", e,
					{TEST_PIN_3, TEST_PIN_2, TEST_PIN_1});
				chk("cp", q,
					{CP_UP, CP_DN, CP_OE});
			end
		end
		// Aux clock through each source and delay setting, divide settings 0 to 6
		c = 4'h7;
		wr(5'h1b, {28'h0, c});
		for (k = 0; k < 28; k = k + 1)
		begin
			wr(5'h19, k % 3);
			wr(5'h18, {k[4:2], k[1:0], 2'h0});
			repeat (40)
			begin
				@(negedge REF_CLK);
				model;
				chk("aux", e,
					{TEST_PIN_3, TEST_PIN_2, TEST_PIN_1});
			end
		end
		// Frequency strobe seen on pin 1 by the scope
		c = 4'h4;
		wr(5'h1b, {28'h0, c});
		repeat (4) @(negedge REF_CLK);
		n0 = edges;
		fv = rs[23:0];
		wr(5'h0c, {8'h0, fv});
		i = 0;
		@(negedge REF_CLK);
		while (FRAC_UPDATE !== 1'b1 && i < 64)
		begin
			@(negedge REF_CLK);
			i = i + 1;
		end
		chk("wait", 0, i == 64);
		chk("frac", fv, FRAC_VALUE);
		repeat (4) @(negedge REF_CLK);
		chk("trig", n0 + 16'h1, edges);
		end_of_test;
	end
endmodule

/* File: tb/synth_test_output_mux_monitor.sv */
`timescale 1ns/100ps
module synth_test_output_mux_monitor
(
	input wire        REF_CLK,
	input wire        RST,
	input wire [4:0]  ADDR,
	input wire [31:0] WDATA,
	input wire        WR,
	input wire        XTAL_REF,
	input wire        SINE_REF,
	input wire        REF_DIV_OUT,
	input wire        PRESCALER_OUT,
	input wire        LOCK_WINDOW,
	input wire        PD_UP,
	input wire        PD_DN,
	input wire        REF_FASTER,
	input wire        VCO_FASTER,
	input wire        MAX_GAIN,
	input wire [2:0]  ACCUM_MSB,
	input wire [2:0]  MOD_OUT_LSB,
	input wire        RING_OSC,
	input wire        MOD_CLK,
	input wire        TEST_PIN_1,
	input wire        TEST_PIN_2,
	input wire        TEST_PIN_3,
	input wire        CP_UP,
	input wire        CP_DN,
	input wire        CP_OE,
	input wire        FRAC_UPDATE
);
	reg  [3:0] sel;
	reg  [2:0] stat;
	reg  [2:0] pd;
	reg  [2:0] age;
	wire [2:0] pins;
	wire       g;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	assign pins = {TEST_PIN_3, TEST_PIN_2, TEST_PIN_1};
	assign g = age == 3'h4;

	// Shadow copies of selector and detector control
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			sel <= 4'h0;
			stat <= 3'h0;
			pd <= 3'h6;
			age <= 3'h0;
		end
		else
		begin
			if (WR && ADDR == 5'h1b)
			begin
				sel <= WDATA[3:0];
				stat <= WDATA[6:4];
			end
			if (WR && ADDR == 5'h05)
				pd <= WDATA[2:0];
			if (!g)
				age <= age + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	static_pins_a: assert property (
		g && $past(sel) == 4'h0 |-> pins == $past(stat)) else $error("static");
	div_pins_a: assert property (
		g && $past(sel) == 4'h1 |-> pins == {$past(XTAL_REF, 3),
		$past(REF_DIV_OUT, 3), $past(PRESCALER_OUT, 3)}) else $error("div");
	lock_pins_a: assert property (
		g && $past(sel) == 4'h2 |-> pins[0] == $past(LOCK_WINDOW, 3)
		&& pins[2] == ($past(pd[0]) ? $past(PD_DN, 3) : $past(PD_UP, 3))
		&& pins[1] == ($past(pd[0]) ? $past(PD_UP, 3) : $past(PD_DN, 3)))
		else $error("lock");
	slip_pins_a: assert property (
		g && $past(sel) == 4'h3 |-> pins[2:1] == {$past(REF_FASTER, 3),
		$past(VCO_FASTER, 3)} && (pins[0] || !$past(MAX_GAIN, 3)))
		else $error("slip");
	accum_pins_a: assert property (
		g && $past(sel) == 4'h6 |-> pins == $past(ACCUM_MSB, 3))
		else $error("accum");
	idle_pins_a: assert property (
		g && $past(sel) inside {4'h5, 4'h8, 4'h9, [4'hb:4'hf]} |->
		pins == 3'h0) else $error("idle");
	cp_drive_a: assert property (
		g |-> CP_UP == (($past(pd[0]) ? $past(PD_DN, 3) : $past(PD_UP, 3))
		& $past(pd[1]))) else $error("cp up");
	cp_tri_a: assert property (
		g |-> CP_OE == ($past(pd[1]) | $past(pd[2]))) else $error("cp oe");
	frac_pulse_a: assert property (
		FRAC_UPDATE |=> !FRAC_UPDATE) else $error("frac pulse");
	frac_pins_a: assert property (
		g && $past(sel) == 4'h4 |-> pins == {$past(SINE_REF, 3),
		$past(REF_DIV_OUT, 3), $past(FRAC_UPDATE)}) else $error("frac pins");
	aux_pins_a: assert property (
		g && $past(sel) == 4'h7 |-> pins[1:0] == {$past(RING_OSC, 3),
		$past(MOD_CLK, 3)}) else $error("aux pins");
	mod_pins_a: assert property (
		g && $past(sel) == 4'ha |-> pins == $past(MOD_OUT_LSB, 3))
		else $error("mod pins");
	cp_down_a: assert property (
		g |-> CP_DN == (($past(pd[0]) ? $past(PD_UP, 3) : $past(PD_DN, 3))
		& $past(pd[2]))) else $error("cp down");
	cover property (g && sel == 4'h2);
	cover property (g && sel == 4'h7 && $rose(TEST_PIN_3));
	cover property (FRAC_UPDATE);
	cover property ($fell(CP_OE));
endmodule

bind synth_test_output_mux synth_test_output_mux_monitor mon (
	.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.XTAL_REF(XTAL_REF), .SINE_REF(SINE_REF), .REF_DIV_OUT(REF_DIV_OUT),
	.PRESCALER_OUT(PRESCALER_OUT), .LOCK_WINDOW(LOCK_WINDOW),
	.PD_UP(PD_UP), .PD_DN(PD_DN), .REF_FASTER(REF_FASTER),
	.VCO_FASTER(VCO_FASTER), .MAX_GAIN(MAX_GAIN), .ACCUM_MSB(ACCUM_MSB),
	.MOD_OUT_LSB(MOD_OUT_LSB), .RING_OSC(RING_OSC), .MOD_CLK(MOD_CLK),
	.TEST_PIN_1(TEST_PIN_1), .TEST_PIN_2(TEST_PIN_2),
	.TEST_PIN_3(TEST_PIN_3), .CP_UP(CP_UP), .CP_DN(CP_DN), .CP_OE(CP_OE),
	.FRAC_UPDATE(FRAC_UPDATE));
